// >>> rsv_pkg.sv
// package: register map, field layout and timing constants for the supervisor
package rsv_pkg;

    // register word offsets (byte addresses, word aligned)
    localparam logic [3:0] REG_CONTROL = 4'h0;
    localparam logic [3:0] REG_MONCFG  = 4'h4;
    localparam logic [3:0] REG_STATUS  = 4'h8;
    localparam logic [3:0] REG_LIVE    = 4'hC;

    // control register fields
    localparam int CTL_SWRST_BIT   = 0;
    localparam int CTL_SWDIS_BIT   = 1;
    localparam int CTL_WDEN_BIT    = 2;
    localparam int CTL_AREGOFF_BIT = 3;

    // monitor configuration fields
    localparam int CFG_DLVL_LSB   = 0;
    localparam int CFG_ALVL_LSB   = 4;
    localparam int CFG_DLV_EN_BIT = 8;
    localparam int CFG_ALV_EN_BIT = 9;
    localparam int CFG_AHV_EN_BIT = 10;
    localparam int CFG_DLV_RST_BIT = 11;
    localparam int CFG_ALV_RST_BIT = 12;
    localparam int LVL_W           = 4;

    // status register fields (sticky, write one to clear)
    localparam int ST_POR_BIT  = 0;
    localparam int ST_WDT_BIT  = 1;
    localparam int ST_SW_BIT   = 2;
    localparam int ST_PRECISE_LOW_VOLTAGE_RESET_BIT = 3;
    localparam int ST_DLV_BIT  = 4;
    localparam int ST_ALV_BIT  = 5;
    localparam int ST_AHV_BIT  = 6;
    localparam int ST_W        = 7;

    // reset values
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
    localparam logic [12:0] MONCFG_RESET  = 13'h0000;

    // timing
    localparam int CLK_MHZ          = 100;
    localparam int POR_MIN_NS       = 150;
    localparam int POR_MIN_CYCLES   = (POR_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int HOLD_W           = 8;
    localparam int WAKE_CYCLES      = 4;

    // power modes from the power-mode controller
    typedef enum logic [1:0] {
        MODE_ACTIVE    = 2'b00,
        MODE_SLEEP     = 2'b01,
        MODE_HIBERNATE = 2'b10
    } power_mode_t;

    // monitor trip indications, treated as digital levels
    typedef struct packed {
        logic initial_power_on_reset_low;    // a supply below the rough power-on level
        logic precise_low_voltage_reset_dig;    // digital regulator out of range
        logic precise_low_voltage_reset_ana;    // analog regulator out of range
        logic dlv_below;   // digital supply below programmed level
        logic alv_below;   // analog supply below programmed level
        logic ahv_above;   // analog supply above fixed high level
    } monitor_t;

    // reset stretch sequencer states
    typedef enum logic [1:0] {
        SEQ_HOLD  = 2'b00,
        SEQ_RUN   = 2'b01,
        SEQ_WAKE  = 2'b10
    } seq_state_t;

    // decode a byte address into a register select
    function automatic logic is_reg(input logic [3:0] addr,
                                    input logic [3:0] reg_off);
        return addr == reg_off;
    endfunction : is_reg

endpackage : rsv_pkg

// >>> reset_sync.sv
// reset synchroniser: asynchronous assert, clean synchronous release
module reset_sync
    import rsv_pkg::*;
(
    input  wire logic clk_in,        // system clock
    input  wire logic async_req_in,  // any reset request, active high
    output logic      sync_rst_out   // released on a clock edge
);
    logic stage;

    // two stages so release never lands near an edge
    always_ff @(posedge clk_in or posedge async_req_in) begin
        if (async_req_in) begin
            stage        <= 1'b1;
            sync_rst_out <= 1'b1;
        end else begin
            stage        <= 1'b0;
            sync_rst_out <= stage;
        end
    end
endmodule : reset_sync

// >>> reset_and_supply_supervisor.sv
// reset and supply supervisor: gathers reset sources, issues device reset
// What this block does
// - reset when a supervised supply leaves range
// - monitors can interrupt before reset thresholds
// - external pin low holds reset, like power-on
// - unserviced watchdog causes reset
// - software reset bit resets like power-on
// - control bit blocks software reset
// - device reset covers processor and peripherals
// - status register records causes, power-on clears
// - power-on pulse min 150 ns, stretched
// - after boot precise monitor takes over
// - precise monitor trip acts like power-on
// - digital precise monitor cannot be disabled
// - precise monitor off in sleep, except buzz
// - high-voltage interrupt at fixed level
// - low-voltage trip levels programmable
// - low-voltage monitor may reset instead
// - monitors off until power-on done, buzz-only sleep
// - sleep interrupt waits for wakeup sequence
// - external reset works in sleep and hibernate
// - watchdog enable sticky until power-on
module reset_and_supply_supervisor
    import rsv_pkg::*;
(
    input  wire logic        clk_in,           // 100 MHz system clock
    input  wire logic        reset_in,         // power-on level, active high
    input  wire monitor_t    monitor_in,       // monitor comparator levels
    input  wire logic        external_reset_n, // external reset pin, low
    input  wire logic        watchdog_expired_in, // watchdog timeout level
    input  wire power_mode_t power_mode_in,    // current power mode
    input  wire logic        buzz_in,          // sleep buzz interval active
    input  wire logic        wake_done_in,     // wakeup sequence complete
    input  wire logic [3:0]  avs_address,      // avalon byte address
    input  wire logic        avs_read,         // avalon read strobe
    input  wire logic        avs_write,        // avalon write strobe
    input  wire logic [31:0] avs_writedata,    // avalon write data
    input  wire logic [3:0]  avs_byteenable,   // avalon byte enables
    output logic [31:0]      avs_readdata,     // avalon read data
    output logic             avs_waitrequest,  // avalon wait request
    output logic             device_reset_out, // reset to core, periph, regs
    output logic             monitor_irq_out,  // supply monitor interrupt
    output logic             wake_req_out,     // ask power control to wake
    output logic [LVL_W-1:0] dlv_level_out,    // digital trip level code
    output logic [LVL_W-1:0] alv_level_out,    // analog trip level code
    output logic             analog_reg_off_out, // analog regulator disable
    output logic             watchdog_en_out   // watchdog enable to timer
);
    logic             sw_reset_bit;
    logic             sw_disable;
    logic             wd_enable;
    logic             areg_off;
    logic [12:0]      moncfg;
    logic [ST_W-1:0]  status;
    logic [ST_W-1:0]  next_status;
    logic             boot_done;
    logic [HOLD_W-1:0] hold_cnt;
    seq_state_t       seq_state;
    logic             por_active;
    logic             precise_low_voltage_reset_trip;
    logic             monitors_live;
    logic             dlv_hit;
    logic             alv_hit;
    logic             ahv_hit;
    logic             dlv_rst;
    logic             alv_rst;
    logic             sw_fire;
    logic             any_req;
    logic             sys_rst;
    logic             irq_pend;
    logic             ack;
    logic             wr_hit;
    logic [2:0]       wake_cnt;

    // power-on sources: the rough monitor and the reset pin of this logic
    assign por_active = reset_in | monitor_in.initial_power_on_reset_low;

    // precise monitor: digital half always on, analog half follows regulator,
    // both only sampled when the regulators are awake or buzzed
    always_comb begin
        monitors_live = boot_done &&
                        (power_mode_in == MODE_ACTIVE ||
                         (power_mode_in == MODE_SLEEP && buzz_in));
        precise_low_voltage_reset_trip = 1'b0;
        if (boot_done && (power_mode_in == MODE_ACTIVE ||
            (power_mode_in == MODE_SLEEP && buzz_in))) begin
            precise_low_voltage_reset_trip = monitor_in.precise_low_voltage_reset_dig
                      | (monitor_in.precise_low_voltage_reset_ana & ~areg_off);
        end
    end

    // low and high supply comparators, gated until power-on finishes
    assign dlv_hit = monitors_live & moncfg[CFG_DLV_EN_BIT]
                   & monitor_in.dlv_below;
    assign alv_hit = monitors_live & moncfg[CFG_ALV_EN_BIT]
                   & monitor_in.alv_below;
    assign ahv_hit = monitors_live & moncfg[CFG_AHV_EN_BIT]
                   & monitor_in.ahv_above;
    assign dlv_rst = dlv_hit & moncfg[CFG_DLV_RST_BIT];
    assign alv_rst = alv_hit & moncfg[CFG_ALV_RST_BIT];

    // software reset fires only when not blocked
    assign sw_fire = sw_reset_bit & ~sw_disable;

    // every source joins here; a pin low works in any power mode
    assign any_req = por_active
                   | precise_low_voltage_reset_trip
                   | ~external_reset_n
                   | (watchdog_expired_in & wd_enable)
                   | sw_fire
                   | dlv_rst | alv_rst;

    // asynchronous assert, synchronous release
    reset_sync u_sync (
        .clk_in       (clk_in),
        .async_req_in (any_req),
        .sync_rst_out (sys_rst)
    );

    // stretch: hold reset at least the power-on minimum after release
    always_ff @(posedge clk_in) begin
        if (sys_rst) begin
            seq_state <= SEQ_HOLD;
            hold_cnt  <= HOLD_W'(POR_MIN_CYCLES);
        end else begin
            case (seq_state)
                SEQ_HOLD: begin
                    if (hold_cnt <= HOLD_W'(1)) begin
                        seq_state <= SEQ_RUN;
                    end else begin
                        hold_cnt <= hold_cnt - HOLD_W'(1);
                    end
                end
                SEQ_RUN:  seq_state <= SEQ_RUN;
                default:  seq_state <= SEQ_HOLD;
            endcase
        end
    end

    // one reset for core, peripherals and every register here but status, watchdog enable, boot flag, stretch sequencer and bus logic
    assign device_reset_out = sys_rst | (seq_state != SEQ_RUN);

    // boot completes when the stretch ends; precise monitor and comparators go live then
    always_ff @(posedge clk_in) begin
        if (por_active) begin
            boot_done <= 1'b0;
        end else if (seq_state == SEQ_RUN) begin
            boot_done <= 1'b1;
        end
    end

    // bus answers in one cycle: waitrequest high on the request cycle
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read | avs_write) & ~ack;
        end
    end
    assign avs_waitrequest = (avs_read | avs_write) & ~ack;
    assign wr_hit          = avs_write & ack;

    // control bits other than watchdog enable cleared by any device reset; the self-clearing reset bit
    // would otherwise loop forever
    always_ff @(posedge clk_in) begin
        if (device_reset_out) begin
            sw_reset_bit <= 1'b0;
            sw_disable   <= CONTROL_RESET[CTL_SWDIS_BIT];
            areg_off     <= CONTROL_RESET[CTL_AREGOFF_BIT];
        end else if (wr_hit && is_reg(avs_address, REG_CONTROL) &&
                     avs_byteenable[0]) begin
            sw_reset_bit <= avs_writedata[CTL_SWRST_BIT];
            sw_disable   <= avs_writedata[CTL_SWDIS_BIT];
            areg_off     <= avs_writedata[CTL_AREGOFF_BIT];
        end
    end

    // watchdog enable: set only, survives all but a power-on reset
    always_ff @(posedge clk_in) begin
        if (por_active) begin
            wd_enable <= 1'b0;
        end else if (wr_hit && is_reg(avs_address, REG_CONTROL) &&
                     avs_byteenable[0] && avs_writedata[CTL_WDEN_BIT]) begin
            wd_enable <= 1'b1;
        end
    end

    // monitor configuration
    always_ff @(posedge clk_in) begin
        if (device_reset_out) begin
            moncfg <= MONCFG_RESET;
        end else if (wr_hit && is_reg(avs_address, REG_MONCFG)) begin
            if (avs_byteenable[0]) begin
                moncfg[7:0] <= avs_writedata[7:0];
            end
            if (avs_byteenable[1]) begin
                moncfg[12:8] <= avs_writedata[12:8];
            end
        end
    end

    // status: sticky, set wins over write-one-to-clear
    always_comb begin
        next_status = status;
        if (wr_hit && is_reg(avs_address, REG_STATUS) && avs_byteenable[0]) begin
            next_status = status & ~avs_writedata[ST_W-1:0];
        end
        if (watchdog_expired_in && wd_enable) begin
            next_status[ST_WDT_BIT] = 1'b1;
        end
        if (sw_fire) begin
            next_status[ST_SW_BIT] = 1'b1;
        end
        if (precise_low_voltage_reset_trip) begin
            next_status[ST_PRECISE_LOW_VOLTAGE_RESET_BIT] = 1'b1;
        end
        if (dlv_hit) begin
            next_status[ST_DLV_BIT] = 1'b1;
        end
        if (alv_hit) begin
            next_status[ST_ALV_BIT] = 1'b1;
        end
        if (ahv_hit) begin
            next_status[ST_AHV_BIT] = 1'b1;
        end
    end

    // of the resets only power-on clears it, so causes survive the reset they made
    always_ff @(posedge clk_in) begin
        if (por_active) begin
            status <= '0;
            status[ST_POR_BIT] <= 1'b1;
        end else begin
            status <= next_status;
        end
    end

    // interrupt pending from non-reset monitor hits
    assign irq_pend = (status[ST_DLV_BIT] & ~moncfg[CFG_DLV_RST_BIT])
                    | (status[ST_ALV_BIT] & ~moncfg[CFG_ALV_RST_BIT])
                    | status[ST_AHV_BIT];

    // in sleep, ask for wake first and present the interrupt after it
    always_ff @(posedge clk_in) begin
        if (device_reset_out) begin
            wake_cnt <= 3'h0;
        end else if (!irq_pend || power_mode_in == MODE_SLEEP) begin
            wake_cnt <= 3'h0;
        end else if (wake_done_in && wake_cnt < 3'(WAKE_CYCLES)) begin
            wake_cnt <= wake_cnt + 3'h1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (device_reset_out) begin
            monitor_irq_out <= 1'b0;
            wake_req_out    <= 1'b0;
        end else begin
            wake_req_out    <= irq_pend & (power_mode_in != MODE_ACTIVE);
            // the wake count makes the interrupt trail a finished wakeup
            monitor_irq_out <= irq_pend &&
                               power_mode_in == MODE_ACTIVE &&
                               wake_done_in &&
                               wake_cnt == 3'(WAKE_CYCLES);
        end
    end

    // read mux, registered
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !ack) begin
            case (avs_address)
                REG_CONTROL: avs_readdata <= {28'h0000000, areg_off,
                                              wd_enable, sw_disable,
                                              sw_reset_bit};
                REG_MONCFG:  avs_readdata <= {19'h00000, moncfg};
                REG_STATUS:  avs_readdata <= {25'h0000000, status};
                REG_LIVE:    avs_readdata <= {26'h0000000,
                                              boot_done, precise_low_voltage_reset_trip,
                                              ahv_hit, alv_hit,
                                              dlv_hit, irq_pend};
                default:     avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    assign dlv_level_out      = moncfg[CFG_DLVL_LSB +: LVL_W];
    assign alv_level_out      = moncfg[CFG_ALVL_LSB +: LVL_W];
    assign analog_reg_off_out = areg_off;
    assign watchdog_en_out    = wd_enable;

endmodule : reset_and_supply_supervisor

// >>> rsv_asserts.sv
// checker: timing ties between reset sources and supervisor outputs
module rsv_asserts
    import rsv_pkg::*;
(
    input wire logic        clk_in,              // system clock
    input wire logic        reset_in,            // power-on level
    input wire monitor_t    monitor_in,          // monitor levels
    input wire logic        external_reset_n,    // external pin, low
    input wire logic        watchdog_expired_in, // watchdog timeout
    input wire power_mode_t power_mode_in,       // power mode
    input wire logic        wake_done_in,        // wakeup finished
    input wire logic        avs_read,            // bus read strobe
    input wire logic        avs_write,           // bus write strobe
    input wire logic        avs_waitrequest,     // bus wait
    input wire logic        device_reset_out,    // device reset
    input wire logic        monitor_irq_out,     // monitor interrupt
    input wire logic        watchdog_en_out      // watchdog enable
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    // the pin holds reset in every mode, sleep and hibernate included
    chk_ext_holds:
    assert property (!external_reset_n |-> device_reset_out)
        else $error("device reset low while external pin held");
    // the rough power-on monitor stretches the pulse while it trips
    chk_por_stretch:
    assert property (monitor_in.initial_power_on_reset_low |-> device_reset_out)
        else $error("device reset low while supply below trip");
    // release only after a full minimum pulse and two quiet sync edges
    chk_release_clean:
    assert property ($fell(device_reset_out) |-> $past(device_reset_out, 15)
                     && !$past(reset_in, 2) && $past(external_reset_n, 2))
        else $error("device reset released too early");
    chk_wdog_reset:
    assert property (watchdog_en_out && watchdog_expired_in
                     |-> ##[0:2] device_reset_out)
        else $error("watchdog expiry gave no reset");
    chk_precise_low_voltage_reset_active:
    assert property (monitor_in.precise_low_voltage_reset_dig && power_mode_in == MODE_ACTIVE
                     |-> ##[0:2] device_reset_out)
        else $error("precise monitor trip gave no reset");
    // enable drops only after a power-on event
    chk_wden_sticky:
    assert property ($fell(watchdog_en_out) |-> $past(monitor_in.initial_power_on_reset_low)
                     || monitor_in.initial_power_on_reset_low || $past(reset_in))
        else $error("watchdog enable cleared without power-on");
    chk_irq_wake:
    assert property ($rose(monitor_irq_out) |-> $past(wake_done_in)
                     && $past(power_mode_in) == MODE_ACTIVE)
        else $error("interrupt shown before wakeup finished");
    // at most one wait cycle for a held request
    chk_wait_one:
    assert property ((avs_read || avs_write) && avs_waitrequest
                     |=> !avs_waitrequest)
        else $error("waitrequest held longer than one cycle");
endmodule : rsv_asserts

// >>> ext_reset_model.sv
// partner: board driver that pulses the external reset pin
module ext_reset_model #(
    parameter int LOW_CYCLES = 20,   // length of one low pulse
    parameter int GAP_CYCLES = 1000  // 10 us at 100 MHz
) (
    input  wire logic clk_in,          // system clock
    input  wire logic pulse_req_in,    // ask for one pulse
    output logic      ext_reset_n_out  // pin level, pulled up when idle
);
    timeunit 1ns;
    timeprecision 100ps;
    int low_cnt = 0;
    int gap_cnt = 0;
    initial ext_reset_n_out = 1'b1;
    // a request inside the recovery gap is dropped, as the pin demands
    always @(posedge clk_in) begin
        if (low_cnt > 0) begin
            low_cnt <= low_cnt - 1;
            if (low_cnt == 1) begin
                ext_reset_n_out <= 1'b1;
                gap_cnt         <= GAP_CYCLES;
            end
        end else begin
            if (gap_cnt > 0) gap_cnt <= gap_cnt - 1;
            if (pulse_req_in && gap_cnt == 0) begin
                ext_reset_n_out <= 1'b0;
                low_cnt         <= LOW_CYCLES;
            end
        end
    end
endmodule : ext_reset_model

// >>> tb.sv
// testbench: reset sources, monitors and registers of the supervisor
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
    n_mismatch++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb
    import rsv_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_in, reset_in, watchdog_expired_in, buzz_in, wake_done_in;
    logic avs_read, avs_write, pulse_req, external_reset_n, seen;
    logic avs_waitrequest, device_reset_out, monitor_irq_out, wake_req_out;
    logic analog_reg_off_out, watchdog_en_out;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd, lf;
    logic [LVL_W-1:0] dlv_level_out, alv_level_out;
    monitor_t monitor_in;
    power_mode_t power_mode_in;
    int n_mismatch = 0;
    int n_compared = 0;
    int cnt, k;

    reset_and_supply_supervisor reset_and_supply_supervisor_inst (
        .clk_in, .reset_in, .monitor_in, .external_reset_n,
        .watchdog_expired_in, .power_mode_in, .buzz_in, .wake_done_in,
        .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest,
        .device_reset_out, .monitor_irq_out, .wake_req_out, .dlv_level_out,
        .alv_level_out, .analog_reg_off_out, .watchdog_en_out);
    ext_reset_model ext_reset_model_inst (.clk_in,
        .pulse_req_in(pulse_req), .ext_reset_n_out(external_reset_n));

    // free-running 100 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    function automatic logic [31:0] bitv(input int b);
        return 32'h1 << b;
    endfunction : bitv

    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    task automatic tmo;
        n_mismatch++;
        $display("[FAIL] wait exp done got timeout");
        close_out();
    endtask : tmo
    // one bus cycle; read data taken while it still stands after the take
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge clk_in);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !wr;
        avs_write     <= wr;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_in);
            if (avs_waitrequest === 1'b0) break;
        end
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (i == 20) tmo();
        @(posedge clk_in);
    endtask : bus
    // look for a reset for 8 cycles, then wait until it has gone
    task automatic rst_chk(output logic s);
        int i;
        s = 1'b0;
        for (i = 0; i < 8; i++) begin
            @(posedge clk_in);
            if (device_reset_out === 1'b1) s = 1'b1;
        end
        for (i = 0; i < 300 && device_reset_out !== 1'b0; i++)
            @(posedge clk_in);
        if (i == 300) tmo();
        repeat (2) @(posedge clk_in);
    endtask : rst_chk
    // pulse one source for a cycle, then look for the reset
    task automatic src_set(input int s, input logic v);
        case (s)
            0: monitor_in.dlv_below <= v;
            1: watchdog_expired_in <= v;
            2: monitor_in.precise_low_voltage_reset_ana <= v;
            default: pulse_req <= v;
        endcase
    endtask : src_set
    task automatic kick(input int s, input logic exp, input string nm);
        src_set(s, 1'b1);
        @(posedge clk_in);
        src_set(s, 1'b0);
        rst_chk(seen);
        `CHK(nm, exp, seen)
    endtask : kick

    // main sequence
    initial begin
        reset_in = 1'b1;  monitor_in = '0;  watchdog_expired_in = 1'b0;
        power_mode_in = MODE_ACTIVE;  buzz_in = 1'b0;  wake_done_in = 1'b1;
        avs_address = 4'h0;  avs_read = 1'b0;  avs_write = 1'b0;
        avs_writedata = 32'h0;  pulse_req = 1'b0;  lf = 32'h9C59;
        repeat (5) @(posedge clk_in);
        reset_in <= 1'b0;
        for (cnt = 0; cnt < 300 && device_reset_out !== 1'b0; cnt++)
            @(posedge clk_in);
        `CHK("por stretch", 1'b1, cnt >= POR_MIN_CYCLES)
        bus(0, REG_STATUS, 0);
        `CHK("status por", bitv(ST_POR_BIT), rd)
        bus(0, REG_CONTROL, 0);
        `CHK("control reset", CONTROL_RESET, rd)
        bus(0, REG_MONCFG, 0);
        `CHK("moncfg reset", 32'(MONCFG_RESET), rd)
        bus(0, 4'h2, 0);
        `CHK("unmapped", 32'h0, rd)
        bus(1, REG_STATUS, 32'hFFFF_FFFF);
        for (k = 0; k < 4; k++) begin
            lf = lfsr(lf);
            bus(1, REG_MONCFG, {24'h0, lf[7:0]});
            `CHK("dlv level", lf[3:0], dlv_level_out)
            `CHK("alv level", lf[7:4], alv_level_out)
        end
        // interrupt in a sleep buzz waits for the wakeup sequence
        bus(1, REG_MONCFG, bitv(CFG_DLV_EN_BIT));
        // buzz kept short against the supply excursion
        power_mode_in <= MODE_SLEEP;  buzz_in <= 1'b1;  wake_done_in <= 1'b0;
        monitor_in.dlv_below <= 1'b1;
        repeat (8) @(posedge clk_in);
        `CHK("wake req", 1'b1, wake_req_out)
        `CHK("irq held", 1'b0, monitor_irq_out)
        power_mode_in <= MODE_ACTIVE;  buzz_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        wake_done_in <= 1'b1;
        repeat (8) @(posedge clk_in);
        `CHK("irq after wake", 1'b1, monitor_irq_out)
        monitor_in.dlv_below <= 1'b0;
        bus(0, REG_STATUS, 0);
        `CHK("status dlv", 1'b1, rd[ST_DLV_BIT])
        bus(1, REG_MONCFG, bitv(CFG_AHV_EN_BIT));
        monitor_in.ahv_above <= 1'b1;
        repeat (8) @(posedge clk_in);
        monitor_in.ahv_above <= 1'b0;
        bus(0, REG_STATUS, 0);
        `CHK("status ahv", 1'b1, rd[ST_AHV_BIT])
        bus(1, REG_MONCFG, bitv(CFG_DLV_EN_BIT) | bitv(CFG_DLV_RST_BIT));
        kick(0, 1'b1, "dlv reset");
        // software reset: first blocked by the disable bit, then taken
        bus(1, REG_MONCFG, {24'h0, lf[15:8]});
        for (k = 0; k < 2; k++) begin
            bus(1, REG_CONTROL, bitv(CTL_SWRST_BIT)
                | (k == 0 ? bitv(CTL_SWDIS_BIT) : 32'h0));
            rst_chk(seen);
            `CHK("sw reset", 1'(k), seen)
        end
        bus(0, REG_MONCFG, 0);
        `CHK("moncfg cleared", 32'h0, rd)
        bus(0, REG_STATUS, 0);
        `CHK("status sw", 1'b1, rd[ST_SW_BIT])
        bus(1, REG_CONTROL, bitv(CTL_WDEN_BIT));
        bus(1, REG_CONTROL, 32'h0);
        `CHK("wden set only", 1'b1, watchdog_en_out)
        kick(1, 1'b1, "wdt reset");
        `CHK("wden kept", 1'b1, watchdog_en_out)
        // precise monitor: active trips, sleep only inside a buzz
        for (k = 0; k < 4; k++) begin
            power_mode_in <= (k == 0) ? MODE_ACTIVE
                           : (k == 3) ? MODE_HIBERNATE : MODE_SLEEP;
            buzz_in <= (k == 2);
            @(posedge clk_in);
            monitor_in.precise_low_voltage_reset_dig <= 1'b1;
            @(posedge clk_in);
            monitor_in.precise_low_voltage_reset_dig <= 1'b0;
            power_mode_in <= MODE_ACTIVE;
            buzz_in <= 1'b0;
            rst_chk(seen);
            `CHK("precise_low_voltage_reset reset", k == 0 || k == 2, seen)
        end
        bus(1, REG_CONTROL, bitv(CTL_AREGOFF_BIT));
        `CHK("areg off", 1'b1, analog_reg_off_out)
        kick(2, 1'b0, "precise_low_voltage_reset ana off");
        power_mode_in <= MODE_HIBERNATE;
        kick(3, 1'b1, "ext reset");
        power_mode_in <= MODE_ACTIVE;
        monitor_in.initial_power_on_reset_low <= 1'b1;
        repeat (30) @(posedge clk_in);
        monitor_in.initial_power_on_reset_low <= 1'b0;
        rst_chk(seen);
        bus(0, REG_STATUS, 0);
        `CHK("status por only", bitv(ST_POR_BIT), rd)
        `CHK("wden cleared", 1'b0, watchdog_en_out)
        close_out();
    end
endmodule : tb
bind reset_and_supply_supervisor rsv_asserts rsv_asserts_inst (
    .clk_in, .reset_in, .monitor_in, .external_reset_n,
    .watchdog_expired_in, .power_mode_in, .wake_done_in, .avs_read,
    .avs_write, .avs_waitrequest, .device_reset_out, .monitor_irq_out,
    .watchdog_en_out);
